// file: rtl/vmesc_ctrl.sv
/*
 * backplane system-controller block: strap decode, clock and reset
 * drive, bus timeout, requester and arbiter, register window decode,
 * with an apb slave for control and status.
 * assumes straps are static and backplane pins are asynchronous.
 */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module vmesc_ctrl #(
    parameter int TIMEOUT_CYC = vmesc_pkg::BUS_TIMEOUT_CYC,
    parameter int SYSRESET_CYC = vmesc_pkg::SYSRESET_HOLD_CYC,
    parameter int SYSCLK_HALF = vmesc_pkg::SYSCLK_HALF_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps, low when installed
    input wire logic cableTxStrap,
    input wire logic sysclkDriveStrap,
    input wire logic sysresetDriveStrap,
    input wire logic timeoutStrap,
    input wire logic grantDriverEnableStrap,
    input wire logic policyStrap,
    input wire logic singleLevelStrap,
    input wire logic [3:0] requestLevelStrap,
    input wire logic [3:0] grantChainLevelStrap,
    input wire logic [7:0] registerWindowLowStrap,
    input wire logic [7:0] registerWindowHighStrap,
    // backplane inputs
    input wire logic asN,
    input wire logic [1:0] dsN,
    input wire logic [15:0] addr,
    input wire logic [5:0] am,
    input wire logic [3:0] brInN,
    input wire logic bbsyInN,
    input wire logic [3:0] bgInN,
    // local logic
    input wire logic localReq,
    input wire logic remoteHit,
    output logic grantAck,
    output logic winSel,
    output logic winRemote,
    output logic winDma,
    output logic [4:0] winOffset,
    // backplane outputs
    output logic sysclkOut,
    output logic sysclkOe,
    output logic sysresetOutN,
    output logic sysresetOe,
    output logic berrOutN,
    output logic berrOe,
    output logic [3:0] arbGrantN,
    output logic arbGrantOe,
    output logic bclrOutN,
    output logic bclrOe,
    output logic [3:0] brOutN,
    output logic [3:0] brOe,
    output logic bbsyOutN,
    output logic bbsyOe,
    output logic [3:0] chainOutN
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int PW = $clog2(SYSRESET_CYC + 1);
    localparam int DW = $clog2(SYSCLK_HALF + 1);

    initial begin
        if (TIMEOUT_CYC < 2 || SYSRESET_CYC < 1 || SYSCLK_HALF < 1) begin
            $error("vmesc_ctrl: counts out of range");
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [30:0] strapS;
    logic [33:0] busS;

    vmesc_sync #(.WIDTH(31)) u_strapSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn({cableTxStrap, sysclkDriveStrap, sysresetDriveStrap,
                timeoutStrap, grantDriverEnableStrap, policyStrap,
                singleLevelStrap, requestLevelStrap, grantChainLevelStrap,
                registerWindowLowStrap, registerWindowHighStrap}),
        .syncOut(strapS)
    );

    vmesc_sync #(.WIDTH(34)) u_busSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn({asN, dsN, addr, am, brInN, bbsyInN, bgInN}),
        .syncOut(busS)
    );

    // installed jumper reads 0
    logic cableOn, clkOn, rstOn, toOn, arbOn, rrOn, singleOn;
    logic [3:0] reqInst, chainInst;
    logic [7:0] winLo, winHi;
    assign cableOn = ~strapS[30]; // [R01]
    assign clkOn = ~strapS[29]; // [R01]
    assign rstOn = ~strapS[28];
    assign toOn = ~strapS[27];
    assign arbOn = ~strapS[26];
    assign rrOn = ~strapS[25]; // [R07]
    assign singleOn = ~strapS[24];
    assign reqInst = ~strapS[23:20];
    assign chainInst = ~strapS[19:16];
    assign winLo = strapS[15:8]; // [R01]
    assign winHi = strapS[7:0];

    logic asAct, dsAct, bbsyFree;
    logic [1:0] dsS;
    logic [15:0] addrS;
    logic [5:0] amS;
    logic [3:0] brPend, bgInS;
    assign asAct = ~busS[33];
    assign dsS = busS[32:31];
    assign dsAct = dsS != 2'h3;
    assign addrS = busS[30:15];
    assign amS = busS[14:9];
    assign brPend = ~busS[8:5];
    assign bbsyFree = busS[4];
    assign bgInS = busS[3:0];

    // lowest installed request jumper names the level; none means 3
    function automatic logic [1:0] strapLevel(input logic [3:0] inst);
        logic [1:0] lvl;
        lvl = vmesc_pkg::SINGLE_LEVEL;
        for (int i = 3; i >= 0; i--) begin
            if (inst[i]) lvl = 2'(i);
        end
        return lvl;
    endfunction : strapLevel

    logic [1:0] reqLevel, chainLevel;
    assign reqLevel = strapLevel(reqInst); // [R09] [R14]
    assign chainLevel = strapLevel(chainInst);

    // ------------------------------------------------------------------
    // apb slave, answers in the first access cycle
    // ------------------------------------------------------------------
    logic swReset_ff, timeoutSeen_ff, remErrSeen_ff, porActive;
    logic [31:0] nxt_rdata;
    logic nxt_err, wrStb, clrTo, clrRem, setTo, setRem;
    vmesc_pkg::vmesc_arb_t arbState_ff;
    logic [1:0] owner_ff;

    always_comb begin
        nxt_rdata = 32'h0;
        nxt_err = 1'b0;
        unique case (paddr)
            vmesc_pkg::REG_CTRL: nxt_rdata[vmesc_pkg::CTRL_SWRST_BIT] =
                swReset_ff;
            vmesc_pkg::REG_STRAP: nxt_rdata[30:0] = strapS;
            vmesc_pkg::REG_STATUS: begin
                nxt_rdata[vmesc_pkg::STAT_TIMEOUT_BIT] = timeoutSeen_ff;
                nxt_rdata[vmesc_pkg::STAT_REMERR_BIT] = remErrSeen_ff;
                nxt_rdata[vmesc_pkg::STAT_MISMATCH_BIT] = winLo != winHi;
                nxt_rdata[vmesc_pkg::STAT_ARB_LSB +: 2] = arbState_ff;
                nxt_rdata[vmesc_pkg::STAT_OWNER_LSB +: 2] = owner_ff;
                nxt_rdata[vmesc_pkg::STAT_POR_BIT] = porActive;
            end
            default: nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~pwrite) ? nxt_rdata : 32'h0;
            pslverr <= psel & ~penable & nxt_err;
        end
    end

    assign wrStb = psel & penable & pready & pwrite & ~pslverr;
    assign clrTo = wrStb && paddr == vmesc_pkg::REG_STATUS &&
        pwdata[vmesc_pkg::STAT_TIMEOUT_BIT];
    assign clrRem = wrStb && paddr == vmesc_pkg::REG_STATUS &&
        pwdata[vmesc_pkg::STAT_REMERR_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            swReset_ff <= vmesc_pkg::CTRL_SWRST_RST;
        end else if (wrStb && paddr == vmesc_pkg::REG_CTRL) begin
            swReset_ff <= pwdata[vmesc_pkg::CTRL_SWRST_BIT];
        end
    end

    // status flags: a new event beats a clearing write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeoutSeen_ff <= 1'b0;
            remErrSeen_ff <= 1'b0;
        end else begin
            timeoutSeen_ff <= setTo | (timeoutSeen_ff & ~clrTo);
            remErrSeen_ff <= setRem | (remErrSeen_ff & ~clrRem);
        end
    end

    // ------------------------------------------------------------------
    // system clock and reset drive
    // ------------------------------------------------------------------
    logic [DW-1:0] divCnt_ff;
    logic [PW-1:0] porCnt_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_ff <= '0;
            sysclkOut <= 1'b0;
            sysclkOe <= 1'b0;
        end else begin
            sysclkOe <= clkOn; // [R03] [R14]
            if (divCnt_ff == DW'(SYSCLK_HALF - 1)) begin
                divCnt_ff <= '0;
                sysclkOut <= ~sysclkOut;
            end else begin
                divCnt_ff <= divCnt_ff + 1'b1;
            end
        end
    end

    // reset is stretched after release so the backplane sees it
    assign porActive = porCnt_ff != PW'(SYSRESET_CYC);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_ff <= '0;
            sysresetOe <= 1'b0;
            sysresetOutN <= 1'b1;
        end else begin
            if (porActive) begin
                porCnt_ff <= porCnt_ff + 1'b1;
            end
            sysresetOe <= rstOn & (porActive | swReset_ff); // [R04] [R14]
            sysresetOutN <= ~(rstOn & (porActive | swReset_ff));
        end
    end

    // ------------------------------------------------------------------
    // bus timeout and remote-access bus error
    // ------------------------------------------------------------------
    logic [TW-1:0] xferCnt_ff;
    assign setTo = toOn & asAct & (xferCnt_ff == TW'(TIMEOUT_CYC - 1));
    assign setRem = ~cableOn & remoteHit & asAct & dsAct; // [R02]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xferCnt_ff <= '0;
        end else if (!asAct) begin
            xferCnt_ff <= '0;
        end else if (xferCnt_ff != TW'(TIMEOUT_CYC)) begin
            xferCnt_ff <= xferCnt_ff + 1'b1; // [R05]
        end
    end

    // error holds until the master drops address strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            berrOe <= 1'b0;
            berrOutN <= 1'b1;
        end else if (!asAct) begin
            berrOe <= 1'b0;
            berrOutN <= 1'b1;
        end else if (setTo | setRem) begin
            berrOe <= 1'b1; // [R05] [R02]
            berrOutN <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register window decode
    // ------------------------------------------------------------------
    logic amOk, winHit;
    assign amOk = amS == vmesc_pkg::AM_SHORT_USER ||
        amS == vmesc_pkg::AM_SHORT_SUPER; // [R13]
    assign winHit = asAct & amOk &
        (addrS[15:vmesc_pkg::WIN_ADDR_LSB] == winLo); // [R12]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            winSel <= 1'b0;
            winRemote <= 1'b0;
            winDma <= 1'b0;
            winOffset <= 5'h0;
        end else begin
            winSel <= winHit;
            winOffset <= winHit ? addrS[4:0] : 5'h0; // [R11]
            winRemote <= winHit & addrS[vmesc_pkg::WIN_REMOTE_BIT]; // [R11]
            winDma <= winHit & addrS[vmesc_pkg::WIN_DMA_BIT]; // [R15]
        end
    end

    // ------------------------------------------------------------------
    // requester and grant daisy chain
    // ------------------------------------------------------------------
    logic owning_ff, ownGrant;
    assign ownGrant = ~bgInS[chainLevel] & localReq & ~owning_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            owning_ff <= 1'b0;
            grantAck <= 1'b0;
            bbsyOe <= 1'b0;
            bbsyOutN <= 1'b1;
            brOe <= 4'h0;
            brOutN <= 4'hf;
            chainOutN <= 4'hf;
        end else begin
            if (ownGrant) begin
                owning_ff <= 1'b1; // [R10]
            end else if (!localReq) begin
                owning_ff <= 1'b0;
            end
            grantAck <= (owning_ff | ownGrant) & localReq;
            bbsyOe <= (owning_ff | ownGrant) & localReq;
            bbsyOutN <= ~((owning_ff | ownGrant) & localReq);
            for (int i = 0; i < 4; i++) begin
                brOe[i] <= localReq & ~owning_ff & ~ownGrant &
                    (reqLevel == 2'(i)); // [R09]
                brOutN[i] <= ~(localReq & ~owning_ff & ~ownGrant &
                    (reqLevel == 2'(i)));
                // own level is held back while we want the bus
                chainOutN[i] <= bgInS[i] |
                    ((chainLevel == 2'(i)) & localReq); // [R10]
            end
        end
    end

    // ------------------------------------------------------------------
    // arbiter
    // ------------------------------------------------------------------
    // priority: highest level; round-robin: next below the last owner
    function automatic logic [1:0] pickLevel(input logic [3:0] req,
                                             input logic rr,
                                             input logic [1:0] last);
        logic [1:0] pick;
        logic [1:0] idx;
        pick = 2'h0;
        idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (req[i]) pick = 2'(i); // [R16]
        end
        if (rr) begin
            for (int i = 4; i >= 1; i--) begin
                idx = last - 2'(i);
                if (req[idx]) pick = idx; // [R07]
            end
        end
        return pick;
    endfunction : pickLevel

    logic [3:0] arbReq, higher;
    logic [1:0] nxt_owner;
    assign arbReq = singleOn ? (brPend & 4'h8) : brPend; // [R08]
    assign nxt_owner = pickLevel(arbReq, rrOn, owner_ff);
    always_comb begin
        higher = 4'h0;
        for (int i = 0; i < 4; i++) begin
            higher[i] = arbReq[i] & (2'(i) > owner_ff);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arbState_ff <= vmesc_pkg::ARB_IDLE;
            owner_ff <= vmesc_pkg::SINGLE_LEVEL;
            arbGrantN <= 4'hf;
            arbGrantOe <= 1'b0;
            bclrOutN <= 1'b1;
            bclrOe <= 1'b0;
        end else begin
            arbGrantOe <= arbOn; // [R06]
            bclrOe <= arbOn; // [R06]
            bclrOutN <= 1'b1;
            unique case (arbState_ff)
                vmesc_pkg::ARB_IDLE: begin
                    if (arbOn && bbsyFree && arbReq != 4'h0) begin
                        arbState_ff <= vmesc_pkg::ARB_GRANT;
                        owner_ff <= nxt_owner;
                        arbGrantN <= ~(4'h1 << nxt_owner);
                    end
                end
                vmesc_pkg::ARB_GRANT: begin
                    if (!bbsyFree) begin
                        arbState_ff <= vmesc_pkg::ARB_HOLD;
                        arbGrantN <= 4'hf;
                    end else if (!arbReq[owner_ff] || !arbOn) begin
                        arbState_ff <= vmesc_pkg::ARB_IDLE;
                        arbGrantN <= 4'hf;
                    end
                end
                vmesc_pkg::ARB_HOLD: begin
                    if (bbsyFree) begin
                        arbState_ff <= vmesc_pkg::ARB_IDLE;
                    end else if (!rrOn && higher != 4'h0) begin
                        bclrOutN <= 1'b0; // [R16]
                    end
                end
                default: begin
                    arbState_ff <= vmesc_pkg::ARB_IDLE;
                    arbGrantN <= 4'hf;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_window_modifier: assert property (winSel |-> // [R13]
        ($past(amS) == 6'h29 || $past(amS) == 6'h2d))
        else $error("window hit with wrong modifier");
    chk_window_match: assert property ( // [R12]
        asAct && amOk && addrS[15:8] == winLo |=> winSel)
        else $error("window not selected on matching address");
    chk_timeout_berr: assert property ( // [R05]
        toOn && asAct && xferCnt_ff == TW'(TIMEOUT_CYC - 1) |=> berrOe)
        else $error("bus timeout did not raise bus error");
    chk_berr_cause: assert property ($rose(berrOe) |-> // [R05]
        $past(setTo) || $past(setRem))
        else $error("bus error without a cause");
    chk_remote_berr: assert property ( // [R02]
        !cableOn && remoteHit && asAct && dsAct |=> berrOe && !berrOutN)
        else $error("remote access without cable strap not refused");
    chk_clk_gate: assert property (!clkOn ##1 !clkOn |-> !sysclkOe) // [R03]
        else $error("system clock driven without strap");
    chk_reset_drive: assert property ( // [R04]
        rstOn && swReset_ff |=> sysresetOe && !sysresetOutN)
        else $error("commanded reset not driven");
    chk_arb_off: assert property (!arbOn ##1 !arbOn |-> // [R06]
        !arbGrantOe && !bclrOe)
        else $error("arbiter outputs driven without strap");
    chk_single_level: assert property ( // [R08]
        singleOn && arbState_ff == vmesc_pkg::ARB_IDLE |=>
        arbGrantN[2:0] == 3'h7)
        else $error("single-level arbiter granted a low level");
    chk_priority_pick: assert property ( // [R16]
        arbOn && !rrOn && !singleOn && bbsyFree && brPend[3] &&
        arbState_ff == vmesc_pkg::ARB_IDLE |=> owner_ff == 2'h3)
        else $error("priority arbiter skipped highest level");
    chk_req_level: assert property (brOe != 4'h0 |-> // [R09]
        $onehot(brOe) && brOe[$past(reqLevel)])
        else $error("request on the wrong level");
    chk_chain_pass: assert property ( // [R10]
        chainLevel != 2'h0 && !bgInS[0] |=> !chainOutN[0])
        else $error("foreign grant not passed on");

    cov_timeout: cover property (toOn && $rose(berrOe));
    cov_own_grant: cover property ($rose(grantAck));
    cov_bclr: cover property ($fell(bclrOutN));
    cov_window: cover property ($rose(winSel) && winDma);
endmodule : vmesc_ctrl
`default_nettype wire

// file: inc/vmesc_pkg.sv
/*
 * constants and types shared by the backplane system-controller block:
 * timing counts, decode values and the register map seen over apb.
 * assumes a single 40 mhz reference clock.
 */
// ----------------------------------------------------------------------
// Operation
// [R01] installed jumper reads 0, removed reads 1
// [R02] no cable strap: remote accesses get bus error
// [R03] drive backplane clock only with strap installed
// [R04] reset strap: drive reset on power-on or command
// [R05] timeout strap: bus error after 48 us transfer
// [R06] arbiter strap: drive four grants and clear
// [R07] policy strap out priority, in round-robin
// [R08] arbiter serves level three only or four levels
// [R09] requester may use any of four levels
// [R10] take own-level grant, pass other grants on
// [R11] decode 32-byte window in four register groups
// [R12] window when a15..a08 equal window straps
// [R13] window answers only modifiers 29 and 2d
// [R14] shipped: requester level 3, drives nothing
// [R15] dma group sits at window offsets 10..1f
// [R16] priority: highest level first, clear on higher
// ----------------------------------------------------------------------
package vmesc_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int BUS_TIMEOUT_US = 48;
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * CLK_MHZ;
    localparam int SYSRESET_HOLD_US = 200;
    localparam int SYSRESET_HOLD_CYC = SYSRESET_HOLD_US * CLK_MHZ;
    localparam int SYSCLK_HALF_CYC = 1;
    // ------------------------------------------------------------------
    // backplane decode
    // ------------------------------------------------------------------
    localparam logic [5:0] AM_SHORT_USER = 6'h29;
    localparam logic [5:0] AM_SHORT_SUPER = 6'h2d;
    localparam int WIN_ADDR_LSB = 8;
    localparam int WIN_REMOTE_BIT = 3;
    localparam int WIN_DMA_BIT = 4;
    localparam logic [1:0] SINGLE_LEVEL = 2'h3;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STRAP = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL_SWRST_BIT = 0;
    localparam logic CTRL_SWRST_RST = 1'b0;
    localparam int STAT_TIMEOUT_BIT = 0;
    localparam int STAT_REMERR_BIT = 1;
    localparam int STAT_MISMATCH_BIT = 2;
    localparam int STAT_ARB_LSB = 4;
    localparam int STAT_OWNER_LSB = 6;
    localparam int STAT_POR_BIT = 8;
    // ------------------------------------------------------------------
    // arbiter states, gray along idle-grant-hold
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_IDLE = 2'h0,
        ARB_GRANT = 2'h1,
        ARB_HOLD = 2'h3
    } vmesc_arb_t;
endpackage : vmesc_pkg

// file: rtl/vmesc_sync.sv
/*
 * two-stage synchroniser for a group of pins.
 * assumes the inputs are asynchronous levels; pulses shorter than
 * one clock may be lost.
 */
`timescale 1ns/1ps
`default_nettype none
module vmesc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pins
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("vmesc_sync: WIDTH must be at least 1");
        end
    end

    // idle level of every grouped pin is high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule : vmesc_sync
`default_nettype wire

// file: bench/vmesc_bp_model.sv
/* backplane partner: one other master that runs an access on command
   and takes any grant the arbiter hands out. assumes the bench holds go
   for as long as the access should last. */
`timescale 1ns/1ps
`default_nettype none
module vmesc_bp_model (
    // clock
    input wire logic ref_clk,
    // command from the bench
    input wire logic go,
    input wire logic [15:0] goAddr,
    input wire logic [5:0] goAm,
    // backplane
    input wire logic [3:0] arbGrantN,
    output logic asN,
    output logic [15:0] addr,
    output logic [5:0] am,
    output logic bbsyInN
);
    initial begin
        asN = 1'b1;
        addr = 16'h0;
        am = 6'h0;
        bbsyInN = 1'b1;
    end
    // released lines toggle so a stale address never decodes by luck
    always @(posedge ref_clk) begin
        asN <= ~go;
        addr <= go ? goAddr : ~addr;
        am <= go ? goAm : ~am;
        bbsyInN <= &arbGrantN;
    end
endmodule : vmesc_bp_model
`default_nettype wire

// file: bench/vmesc_ctrl_test.sv
/* self-checking bench for the system-controller block.
   assumes the partner model drives the backplane access and busy lines. */
`timescale 1ns/1ps
`default_nettype none
module vmesc_ctrl_test;
    localparam int TOC = 40;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, go;
    logic cableTxStrap, sysclkDriveStrap, sysresetDriveStrap, timeoutStrap;
    logic grantDriverEnableStrap, policyStrap, singleLevelStrap, asN;
    logic bbsyInN, localReq, remoteHit, grantAck, winSel, winRemote, winDma;
    logic sysclkOut, sysclkOe, sysresetOutN, sysresetOe, berrOutN, berrOe;
    logic arbGrantOe, bclrOutN, bclrOe, bbsyOutN, bbsyOe;
    logic [3:0] requestLevelStrap, grantChainLevelStrap, brInN, bgInN;
    logic [3:0] arbGrantN, brOutN, brOe, chainOutN;
    logic [7:0] registerWindowLowStrap, registerWindowHighStrap;
    logic [1:0] dsN;
    logic [15:0] addr, goAddr;
    logic [5:0] am, goAm;
    logic [4:0] winOffset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er;
    int miscompares, compares, n;
    vmesc_ctrl #(.TIMEOUT_CYC(TOC), .SYSRESET_CYC(20)) i_dut (.*);
    vmesc_bp_model i_bp (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        if (n >= 20) end_of_test();
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic s_shipped;
        check("clkOe", sysclkOe, 0);
        check("rstOe", sysresetOe, 0);
        check("grOe", {arbGrantOe, bclrOe}, 0);
        localReq <= 1'b1; bgInN <= 4'hc;
        repeat (5) @(posedge ref_clk);
        check("brOe", brOe, 4'h8);
        check("brOut", brOutN, 4'h7);
        check("pass", {grantAck, chainOutN}, 5'h0c);
        bgInN <= 4'h7;
        repeat (5) @(posedge ref_clk);
        check("ack", grantAck, 1);
        check("own", {bbsyOe, bbsyOutN, brOe}, 6'h20);
        localReq <= 1'b0; bgInN <= 4'hf;
        go <= 1'b1; goAddr <= 16'h2018; goAm <= 6'h2d;
        repeat (5) @(posedge ref_clk);
        check("win", {winSel, winRemote, winDma, winOffset},
            8'hf8);
        repeat (TOC + 8) @(posedge ref_clk);
        check("noTo", berrOe, 0);
        remoteHit <= 1'b1; dsN <= 2'h0;
        repeat (5) @(posedge ref_clk);
        check("remErr", {berrOe, berrOutN}, 2'h2);
        remoteHit <= 1'b0; dsN <= 2'h3; goAm <= 6'h09;
        repeat (5) @(posedge ref_clk);
        check("amOff", winSel, 0);
        goAm <= 6'h29; goAddr <= 16'h2105;
        repeat (5) @(posedge ref_clk);
        check("adOff", winSel, 0);
        go <= 1'b0;
    endtask : s_shipped
    task automatic s_regs;
        apb(0, 12'h004, 0);
        check("strap", rd, {1'b0, 7'h7f, 8'h77, 16'h2020});
        apb(0, 12'hffc, 0);
        check("unmapErr", er, 1);
        check("unmapData", rd, 0);
    endtask : s_regs
    task automatic s_master;
        {sysclkDriveStrap, sysresetDriveStrap, timeoutStrap} <= 3'h0;
        grantDriverEnableStrap <= 1'b0;
        rst_n <= 1'b0;
        @(posedge ref_clk) rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("porRst", {sysresetOe, sysresetOutN}, 2'h2);
        repeat (30) @(posedge ref_clk);
        check("porEnd", sysresetOe, 0);
        check("clkOe", sysclkOe, 1);
        er = sysclkOut;
        @(posedge ref_clk);
        check("sysclk", sysclkOut, !er);
        apb(1, 12'h000, 1);
        repeat (4) @(posedge ref_clk);
        check("swRst", {sysresetOe, sysresetOutN}, 2'h2);
        apb(1, 12'h000, 0);
        go <= 1'b1; goAddr <= 16'h3000;
        repeat (TOC + 8) @(posedge ref_clk);
        check("to", {berrOe, berrOutN}, 2'h2);
        go <= 1'b0; brInN <= 4'hb;
        n = 0;
        while (arbGrantN !== 4'hb && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        check("grant", {arbGrantOe, arbGrantN}, 5'h1b);
        brInN <= 4'hf;
    endtask : s_master
    initial begin
        {rst_n, psel, penable, pwrite, go, localReq, remoteHit} = 7'h0;
        {cableTxStrap, sysclkDriveStrap, sysresetDriveStrap} = 3'h7;
        {timeoutStrap, grantDriverEnableStrap, policyStrap} = 3'h7;
        singleLevelStrap = 1'b1;
        requestLevelStrap = 4'h7;
        grantChainLevelStrap = 4'h7;
        registerWindowLowStrap = 8'h20;
        registerWindowHighStrap = 8'h20;
        {paddr, pwdata, goAddr, goAm} = 0;
        {dsN, brInN, bgInN} = 10'h3ff;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge ref_clk);
        s_shipped();
        s_regs();
        s_master();
        end_of_test();
    end
endmodule : vmesc_ctrl_test
`default_nettype wire
